// *** src/igtp_pkg.sv ***
// shared constants and carrier types for the irq gate and tx list pointer block
// Operation
// - gate bit 0 at one lets pending unmasked events drive the interrupt line
// - gate bit 0 at zero holds the interrupt line inactive
// - writing the gate changes neither interrupt status nor interrupt mask
// - while active the pointer follows each descriptor along the list
// - a null link keeps the pointer on the current descriptor
// - a go write while idle, or on the null answer, rereads the link of the current descriptor; a go at other busy times is ignored
// - a status bit counts only with its mask bit, then gate decides
// - status bits set on their event whatever the mask says
package igtp_pkg;

  localparam int unsigned ADR_W      = 8;
  localparam int unsigned EVT_W      = 4;

  localparam logic [7:0]  CMD_OFF    = 8'h00;
  localparam logic [7:0]  STATUS_OFF = 8'h10;
  localparam logic [7:0]  MASK_OFF   = 8'h14;
  localparam logic [7:0]  GATE_OFF   = 8'h18;
  localparam logic [7:0]  PTR_OFF    = 8'h20;

  localparam int unsigned GATE_EN_BIT = 0;
  localparam int unsigned GO_BIT      = 0;
  localparam int unsigned PTR_LSB     = 2;

  localparam int unsigned EV_ADV  = 0;
  localparam int unsigned EV_END  = 1;
  localparam int unsigned EV_EXT0 = 2;

  localparam logic [31:0] GATE_RST   = 32'h0000_0000;
  localparam logic [31:0] PTR_RST    = 32'h0000_0000;
  localparam logic [3:0]  STATUS_RST = 4'h0;
  localparam logic [3:0]  MASK_RST   = 4'h0;
  localparam logic [31:0] NULL_LINK  = 32'h0000_0000;

  typedef enum {W_IDLE, W_FETCH} igtp_walk_e;

  typedef struct packed {
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } igtp_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] data;
  } igtp_link_s;

  function automatic logic [31:0] igtp_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

endpackage

// *** src/igtp_irq_gate.sv ***
// interrupt status, mask and global gate with the registered line
`timescale 1ns/1ns
`default_nettype none
module igtp_irq_gate
  import igtp_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wr_gate,
  input  wire logic             wr_mask,
  input  wire logic             rd_clear,
  input  wire logic [31:0]      wdata,
  input  wire logic [EVT_W-1:0] evt,
  output logic                  gate_q,
  output logic [EVT_W-1:0]      mask_q,
  output logic [EVT_W-1:0]      status_q,
  output logic                  line_q
);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      gate_q <= GATE_RST[GATE_EN_BIT];
    else if (wr_gate)
      gate_q <= wdata[GATE_EN_BIT];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mask_q <= MASK_RST;
    else if (wr_mask)
      mask_q <= wdata[EVT_W-1:0];
  end

  // read clears only the bits it returned, so later events survive
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      status_q <= STATUS_RST;
    else
      status_q <= (rd_clear ? (status_q & ~wdata[EVT_W-1:0]) : status_q) | evt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      line_q <= 1'b0;
    else
      line_q <= gate_q && |(status_q & mask_q);
  end

endmodule // igtp_irq_gate
`default_nettype wire

// *** src/igtp_tx_walk.sv ***
// transmit list walker holding the descriptor pointer
`timescale 1ns/1ns
`default_nettype none
module igtp_tx_walk
  import igtp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic        wr_ptr,
  input  wire logic [31:0] wdata,
  input  wire igtp_link_s  link,
  output logic [31:2]      ptr_q,
  output logic             busy_q,
  output logic             req_q,
  output logic             evt_adv_q,
  output logic             evt_end_q
);

  igtp_walk_e state_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q   <= W_IDLE;
      busy_q    <= 1'b0;
      req_q     <= 1'b0;
      evt_adv_q <= 1'b0;
      evt_end_q <= 1'b0;
    end
    else
    begin
      evt_adv_q <= 1'b0;
      evt_end_q <= 1'b0;
      case (state_q)
        W_IDLE:
        begin
          if (go)
          begin
            state_q <= W_FETCH;
            busy_q  <= 1'b1;
            req_q   <= 1'b1;
          end
        end
        W_FETCH:
        begin
          // a go on the null answer rereads instead of stopping
          if (link.ack && link.data == NULL_LINK && !go)
          begin
            state_q   <= W_IDLE;
            busy_q    <= 1'b0;
            req_q     <= 1'b0;
            evt_end_q <= 1'b1;
          end
          else if (link.ack && link.data != NULL_LINK)
            evt_adv_q <= 1'b1;
        end
        default:
        begin
          state_q <= W_IDLE;
          busy_q  <= 1'b0;
          req_q   <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ptr_q <= PTR_RST[31:PTR_LSB];
    else if (state_q == W_FETCH && link.ack && link.data != NULL_LINK)
      ptr_q <= link.data[31:PTR_LSB];
    else if (wr_ptr && state_q == W_IDLE)
      ptr_q <= wdata[31:PTR_LSB];
  end

endmodule // igtp_tx_walk
`default_nettype wire

// *** src/igtp_top.sv ***
// wishbone register slice: interrupt gate and transmit list pointer
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module igtp_top
  import igtp_pkg::*;
(
  input  wire logic             REF_CLK,
  input  wire logic             SYS_RST,
  input  wire logic             WB_CYC_I,
  input  wire logic             WB_STB_I,
  input  wire logic             WB_WE_I,
  input  wire logic [ADR_W-1:0] WB_ADR_I,
  input  wire logic [3:0]       WB_SEL_I,
  input  wire logic [31:0]      WB_DAT_I,
  output logic [31:0]           WB_DAT_O,
  output logic                  WB_ACK_O,
  input  wire logic [1:0]       EXT_EVT,
  input  wire logic             LINK_RD_ACK,
  input  wire logic [31:0]      LINK_RD_DATA,
  output logic                  LINK_RD_REQ,
  output logic [31:0]           LINK_RD_ADDR,
  output logic                  TX_BUSY,
  output logic                  HOST_IRQ_LINE
);

  igtp_req_s        req;
  igtp_link_s       link;
  logic             ack_q;
  logic             take;
  logic             wr_take;
  logic             rd_take;
  logic             wr_cmd;
  logic             wr_gate;
  logic             wr_mask;
  logic             wr_ptr;
  logic             rd_status;
  logic             go;
  logic [31:0]      gate_word;
  logic [31:0]      ptr_word;
  logic [31:0]      mask_word;
  logic [31:0]      status_word;
  logic [31:0]      rd_d;
  logic [31:0]      wmerge_gate;
  logic [31:0]      wmerge_ptr;
  logic [31:0]      wmerge_mask;
  logic             gate_q;
  logic [EVT_W-1:0] mask_q;
  logic [EVT_W-1:0] status_q;
  logic [EVT_W-1:0] evt;
  logic [31:2]      ptr_q;
  logic             busy_q;
  logic             req_q;
  logic             evt_adv_q;
  logic             evt_end_q;
  logic             line_q;
  logic [31:0]      dat_q;

  assign req  = {WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I};
  assign link = {LINK_RD_ACK, LINK_RD_DATA};

  // a transfer is taken at the edge where ack is already high
  assign take    = WB_CYC_I && WB_STB_I && ack_q;
  assign wr_take = take && req.we;
  assign rd_take = take && !req.we;

  assign wr_cmd    = wr_take && req.adr == CMD_OFF;
  assign wr_gate   = wr_take && req.adr == GATE_OFF;
  assign wr_mask   = wr_take && req.adr == MASK_OFF;
  assign wr_ptr    = wr_take && req.adr == PTR_OFF;
  assign rd_status = rd_take && req.adr == STATUS_OFF;
  assign go        = wr_cmd && req.sel[0] && req.dat[GO_BIT];

  assign gate_word   = {31'h0000_0000, gate_q};
  assign ptr_word    = {ptr_q, 2'b00};
  assign mask_word   = {28'h000_0000, mask_q};
  assign status_word = {28'h000_0000, status_q};

  // byte lanes merge into the current value before the store
  assign wmerge_gate = igtp_merge(gate_word, req.dat, req.sel);
  assign wmerge_ptr  = igtp_merge(ptr_word, req.dat, req.sel);
  assign wmerge_mask = igtp_merge(mask_word, req.dat, req.sel);

  assign evt = {EXT_EVT, evt_end_q, evt_adv_q};

  igtp_irq_gate u_irq (
    .clk      (REF_CLK),
    .rst      (SYS_RST),
    .wr_gate  (wr_gate),
    .wr_mask  (wr_mask && req.sel[0]),
    .rd_clear (rd_status),
    .wdata    (wr_gate ? wmerge_gate : (rd_status ? dat_q : wmerge_mask)),
    .evt      (evt),
    .gate_q   (gate_q),
    .mask_q   (mask_q),
    .status_q (status_q),
    .line_q   (line_q)
  );

  igtp_tx_walk u_walk (
    .clk       (REF_CLK),
    .rst       (SYS_RST),
    .go        (go),
    .wr_ptr    (wr_ptr),
    .wdata     (wmerge_ptr),
    .link      (link),
    .ptr_q     (ptr_q),
    .busy_q    (busy_q),
    .req_q     (req_q),
    .evt_adv_q (evt_adv_q),
    .evt_end_q (evt_end_q)
  );

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      ack_q <= 1'b0;
    else
      ack_q <= WB_CYC_I && WB_STB_I && !ack_q;
  end

  always_comb
  begin
    case (req.adr)
      CMD_OFF:    rd_d = {31'h0000_0000, busy_q};
      STATUS_OFF: rd_d = status_word;
      MASK_OFF:   rd_d = mask_word;
      GATE_OFF:   rd_d = gate_word;
      PTR_OFF:    rd_d = ptr_word;
      default:    rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      dat_q <= 32'h0000_0000;
    else if (WB_CYC_I && WB_STB_I && !ack_q && !req.we)
      dat_q <= rd_d;
    else if (!ack_q)
      dat_q <= 32'h0000_0000;
  end

  assign WB_ACK_O      = ack_q;
  assign WB_DAT_O      = dat_q;
  assign LINK_RD_REQ   = req_q;
  assign LINK_RD_ADDR  = ptr_word;
  assign TX_BUSY       = busy_q;
  assign HOST_IRQ_LINE = line_q;

  // checks on the design's own behaviour
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);

  sequence go_write_s;
    go && !busy_q;
  endsequence

  sequence fetch_cur_s;
    LINK_RD_REQ && TX_BUSY && LINK_RD_ADDR == $past(ptr_word);
  endsequence

  sequence link_next_s;
    busy_q && link.ack && link.data != NULL_LINK;
  endsequence

  sequence link_null_s;
    busy_q && link.ack && link.data == NULL_LINK && !go;
  endsequence

  sequence go_at_end_s;
    busy_q && link.ack && link.data == NULL_LINK && go;
  endsequence

  gate_open_a: assert property (
    gate_q && |(status_q & mask_q) |=> HOST_IRQ_LINE)
    else $error("line stayed low with gate open and event pending");

  gate_shut_a: assert property (
    !gate_q |=> !HOST_IRQ_LINE)
    else $error("line high while gate closed");

  gate_keeps_a: assert property (
    wr_gate && !rd_status |=> $stable(mask_q) && ((status_q & $past(status_q)) == $past(status_q)))
    else $error("gate write disturbed status or mask");

  ptr_busy_a: assert property (
    busy_q && !link.ack && wr_ptr |=> $stable(ptr_q))
    else $error("pointer written while walker active");

  ptr_follow_a: assert property (
    link_next_s |=> ptr_q == $past(link.data[31:2]) ##1 status_q[EV_ADV])
    else $error("pointer did not follow link");

  ptr_hold_a: assert property (
    link_null_s |=> $stable(ptr_q) && !TX_BUSY && !LINK_RD_REQ ##1 status_q[EV_END])
    else $error("pointer moved on null link");

  end_reread_a: assert property (
    go_at_end_s |=> TX_BUSY && LINK_RD_REQ && $stable(ptr_q))
    else $error("go on null link did not reread");

  go_reread_a: assert property (
    go_write_s |=> fetch_cur_s)
    else $error("go write did not reread link");

  addr_follow_a: assert property (
    link_next_s |=> LINK_RD_ADDR == {$past(link.data[31:2]), 2'b00})
    else $error("link address did not follow pointer");

  mask_block_a: assert property (
    !(|(status_q & mask_q)) |=> !HOST_IRQ_LINE)
    else $error("line high with no unmasked status");

  status_set_a: assert property (
    EXT_EVT[0] |=> status_q[EV_EXT0])
    else $error("event did not set status");

  unused_zero_a: assert property (
    WB_ACK_O && !req.we && req.adr == GATE_OFF |-> WB_DAT_O[31:1] == 31'h0000_0000)
    else $error("unused gate bits read nonzero");

  irq_exact_a: assert property (
    ##1 HOST_IRQ_LINE == $past(gate_q && |(status_q & mask_q)))
    else $error("line differs from gated request");

endmodule // igtp_top
`default_nettype wire

// *** verif/igtp_mem_model.sv ***
// descriptor memory model answering link-field reads of the walker
`timescale 1ns/1ns
`default_nettype none
module igtp_mem_model
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] end_addr,
  input  wire logic [3:0]  lat,
  output logic             ack,
  output logic [31:0]      data
);
  logic [3:0] cnt_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack   <= 1'b0;
      data  <= 32'h0000_0000;
      cnt_q <= 4'h0;
    end
    else if (req && !ack && cnt_q >= lat)
    begin
      ack   <= 1'b1;
      // word-aligned links, null at the list end
      data  <= (addr < end_addr) ? addr + 32'h0000_0010 : 32'h0000_0000;
      cnt_q <= 4'h0;
    end
    else
    begin
      ack   <= 1'b0;
      // stale data never holds outside the answer
      data  <= ~data;
      cnt_q <= (req && !ack) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule // igtp_mem_model
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench for the irq gate and tx list pointer slice
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import igtp_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we  = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [1:0]  evt = 2'b00;
  logic [3:0]  sel = 4'hF;
  logic [3:0]  lanes = 4'hF;
  logic [31:0] rdata;
  logic        ack;
  logic        l_ack;
  logic [31:0] l_data;
  logic        l_req;
  logic [31:0] l_addr;
  logic        busy;
  logic        line;
  logic [31:0] end_a = 32'h0000_0000;
  logic [3:0]  lat = 4'h1;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  always #2 clk = ~clk;

  igtp_top uut (.REF_CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdata), .WB_ACK_O(ack),
    .EXT_EVT(evt), .LINK_RD_ACK(l_ack), .LINK_RD_DATA(l_data), .LINK_RD_REQ(l_req),
    .LINK_RD_ADDR(l_addr), .TX_BUSY(busy), .HOST_IRQ_LINE(line));

  igtp_mem_model mem (.clk(clk), .rst(rst), .req(l_req), .addr(l_addr), .end_addr(end_a),
    .lat(lat), .ack(l_ack), .data(l_data));

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic summarize;
    $display("compares %0d, miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= lanes;
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    r = rdata;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, a, 32'h0000_0000, r);
    chk(what, r, exp);
  endtask

  task automatic wait_idle;
    repeat (3) @(posedge clk);
    while (busy !== 1'b0)
    begin
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask

  task automatic pulse(input logic [1:0] e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= 2'b00;
    repeat (3) @(posedge clk);
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      summarize;
    end
  end

  initial
  begin
    logic [15:0] s;
    logic [31:0] start;
    int          k;
    s = 16'h51EB;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc("gate reset", GATE_OFF, GATE_RST);
    rdc("pointer reset", PTR_OFF, PTR_RST);
    rdc("unmapped", 8'h40, 32'h0000_0000);
    wr(GATE_OFF, 32'hFFFF_FFFF);
    rdc("gate unused bits", GATE_OFF, 32'h0000_0001);
    lanes = 4'hE;
    wr(GATE_OFF, 32'h0000_0000);
    lanes = 4'hF;
    rdc("gate lane off", GATE_OFF, 32'h0000_0001);
    $display("register test done");
    wr(MASK_OFF, 32'h0000_0004);
    pulse(2'b01);
    chk("line enabled", {31'h0, line}, 32'h1);
    wr(GATE_OFF, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk("line gated", {31'h0, line}, 32'h0);
    rdc("mask kept", MASK_OFF, 32'h0000_0004);
    rdc("status kept", STATUS_OFF, 32'h0000_0004);
    wr(GATE_OFF, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("line after clear", {31'h0, line}, 32'h0);
    pulse(2'b10);
    chk("masked event", {31'h0, line}, 32'h0);
    rdc("masked status", STATUS_OFF, 32'h0000_0008);
    $display("interrupt test done");
    for (int i = 0; i < 6; i++)
    begin
      s = lfsr_next(s);
      start = {20'h0_0000, s[7:0], 4'h0};
      k = 3 + int'(s[12:11]);
      lat <= (i == 0) ? 4'h1 : {1'b0, s[10:8]} + 4'h2;
      end_a <= start + 32'(k * 16);
      // loaded only while the walker is idle
      wr(PTR_OFF, start | {30'h0, s[14:13]});
      rdc("pointer load", PTR_OFF, start);
      wr(CMD_OFF, 32'h0000_0001);
      wr(PTR_OFF, {s, s});
      rdc("busy walking", CMD_OFF, 32'h0000_0001);
      wait_idle;
      rdc("pointer walk", PTR_OFF, start + 32'(k * 16));
      rdc("walk status", STATUS_OFF, 32'h0000_0003);
      end_a <= end_a + 32'h0000_0020;
      wr(CMD_OFF, 32'h0000_0001);
      wait_idle;
      rdc("pointer append", PTR_OFF, start + 32'(k * 16 + 32));
      $display("walk test %0d done", i);
    end
    summarize;
  end
endmodule // testbench
`default_nettype wire
